// ===== src/bxs_pkg.sv
package bxs_pkg;
    // widths of the datapath
    localparam int ADDR_W = 24;
    localparam int PARCEL_W = 16;
    localparam int SREG_W = 64;
    localparam int XADR_W = 8;
    // parcel-0 field positions
    localparam int OPC_HI = 15;
    localparam int OPC_LO = 9;
    localparam int I_TOP = 8;
    localparam int I_LO = 6;
    localparam int TGT_HI = 7;
    // opcode values, top seven bits of parcel 0
    localparam logic [6:0] OPC_EXIT = 7'h04;
    localparam logic [6:0] OPC_JUMP_B = 7'h05;
    localparam logic [6:0] OPC_JUMP = 7'h06;
    localparam logic [6:0] OPC_RET_JUMP = 7'h07;
    localparam logic [3:0] OPC_BR_GROUP = 4'h1;
    // low three opcode bits select the branch test
    localparam logic [2:0] BR_A_ZERO = 3'h0;
    localparam logic [2:0] BR_A_NONZERO = 3'h1;
    localparam logic [2:0] BR_A_POS = 3'h2;
    localparam logic [2:0] BR_A_NEG = 3'h3;
    localparam logic [2:0] BR_S_ZERO = 3'h4;
    localparam logic [2:0] BR_S_NONZERO = 3'h5;
    localparam logic [2:0] BR_S_POS = 3'h6;
    localparam logic [2:0] BR_S_NEG = 3'h7;
    // parcel steps
    localparam logic [ADDR_W-1:0] STEP_ONE = 24'h000001;
    localparam logic [ADDR_W-1:0] STEP_TWO = 24'h000002;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 24'h000000;
    localparam logic [XADR_W-1:0] XADR_ZERO = 8'h00;

    typedef enum logic [1:0] {ST_IDLE, ST_DRAIN, ST_EXCH} bxs_state_type;

    typedef struct packed {
        logic valid;
        logic [PARCEL_W-1:0] parcel0;
        logic [PARCEL_W-1:0] parcel1;
        logic [ADDR_W-1:0] p_addr;
        logic [ADDR_W-1:0] bjk;
        logic [ADDR_W-1:0] a0;
        logic [SREG_W-1:0] s0;
    } bxs_issue_type;

    typedef struct packed {
        logic valid;
        logic taken;
        logic [ADDR_W-1:0] target;
    } bxs_flow_type;

    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] data;
    } bxs_link_type;

    typedef struct packed {
        logic req;
        logic [XADR_W-1:0] xadr;
        logic [ADDR_W-1:0] save_p;
    } bxs_exch_type;
endpackage

// ===== src/bxs_top.sv
// How it works
// - normal exit starts an exchange and voids the instruction buffers.
// - outside monitor mode a normal exit sets the normal-exit flag.
// - exchange waits until earlier results reach the operating registers.
// - exchange goes to the package named by the exchange address.
// - saved program address is exit address plus one parcel.
// - the exit's ijk fields are ignored.
// - register jump loads the program address from the selected B register.
// - immediate jump loads the low 24 bits of its address field.
// - return jump writes address plus two into the return link, then jumps.
// - address-test branches check zero, nonzero, positive, negative; jump if true.
// - a zero address test value counts as positive.
// - scalar-test branches check zero, nonzero, positive, negative; jump if true.
// - a zero scalar test value counts as positive.
// - a failed branch continues with the next instruction.
`timescale 1ns/10ps
`default_nettype none
module bxs_top (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire bxs_pkg::bxs_issue_type i_issue,
    input wire logic i_monitor_mode,
    input wire logic i_pending,
    input wire logic [bxs_pkg::XADR_W-1:0] i_xadr,
    input wire logic i_exch_ack,
    output logic o_ready,
    output bxs_pkg::bxs_flow_type o_flow,
    output bxs_pkg::bxs_link_type o_link,
    output logic o_flush,
    output logic o_ne_flag_set,
    output bxs_pkg::bxs_exch_type o_exch
);
    import bxs_pkg::*;

    typedef struct packed {
        bxs_state_type st;
        logic ready;
        bxs_flow_type flow;
        bxs_link_type link;
        logic flush;
        logic ne_set;
        bxs_exch_type exch;
    } bxs_regs_type;

    bxs_regs_type state_reg;
    bxs_regs_type state_next;
    logic accept;
    logic [6:0] opc;
    logic i_top;
    logic [ADDR_W-1:0] target;
    logic cond_ok;

    // decode fields; exit is matched on opcode alone
    assign accept = i_issue.valid && state_reg.ready;
    assign opc = i_issue.parcel0[OPC_HI:OPC_LO];
    assign i_top = i_issue.parcel0[I_TOP];
    assign target = {i_issue.parcel0[TGT_HI:0], i_issue.parcel1};

    // branch test; sign bit alone decides, so zero reads positive
    always_comb begin
        unique case (opc[2:0])
            BR_A_ZERO: cond_ok = (i_issue.a0 == ADDR_ZERO);
            BR_A_NONZERO: cond_ok = (i_issue.a0 != ADDR_ZERO);
            BR_A_POS: cond_ok = !i_issue.a0[ADDR_W-1];
            BR_A_NEG: cond_ok = i_issue.a0[ADDR_W-1];
            BR_S_ZERO: cond_ok = (i_issue.s0 == '0);
            BR_S_NONZERO: cond_ok = (i_issue.s0 != '0);
            BR_S_POS: cond_ok = !i_issue.s0[SREG_W-1];
            BR_S_NEG: cond_ok = i_issue.s0[SREG_W-1];
        endcase
    end

    // next-state logic; pulses drop back by default
    always_comb begin
        state_next = state_reg;
        state_next.flow.valid = 1'b0;
        state_next.link.we = 1'b0;
        state_next.flush = 1'b0;
        state_next.ne_set = 1'b0;
        unique case (state_reg.st)
            ST_IDLE: begin
                if (accept) begin
                    if (opc == OPC_EXIT) begin
                        state_next.flush = 1'b1;
                        state_next.ne_set = !i_monitor_mode;
                        state_next.exch.save_p = i_issue.p_addr + STEP_ONE;
                        state_next.ready = 1'b0;
                        state_next.st = ST_DRAIN;
                    end else if (opc == OPC_JUMP_B && i_issue.parcel0[I_TOP:I_LO] == 3'h0) begin
                        state_next.flow.valid = 1'b1;
                        state_next.flow.taken = 1'b1;
                        state_next.flow.target = i_issue.bjk;
                    end else if (opc == OPC_JUMP) begin
                        state_next.flow.valid = 1'b1;
                        state_next.flow.taken = 1'b1;
                        state_next.flow.target = target;
                    end else if (opc == OPC_RET_JUMP) begin
                        state_next.link.we = 1'b1;
                        state_next.link.data = i_issue.p_addr + STEP_TWO;
                        state_next.flow.valid = 1'b1;
                        state_next.flow.taken = 1'b1;
                        state_next.flow.target = target;
                    end else if (opc[6:3] == OPC_BR_GROUP && !i_top) begin
                        state_next.flow.valid = 1'b1;
                        state_next.flow.taken = cond_ok;
                        // failed test falls through past both parcels
                        state_next.flow.target = cond_ok ? target
                            : i_issue.p_addr + STEP_TWO;
                    end
                end
            end
            ST_DRAIN: begin
                // hold off until nothing is still in flight
                if (!i_pending) begin
                    state_next.exch.req = 1'b1;
                    state_next.exch.xadr = i_xadr;
                    state_next.st = ST_EXCH;
                end
            end
            ST_EXCH: begin
                // request stands until the exchange logic takes it
                if (i_exch_ack) begin
                    state_next.exch.req = 1'b0;
                    state_next.ready = 1'b1;
                    state_next.st = ST_IDLE;
                end
            end
        endcase
    end

    // one register for all state
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg.st <= ST_IDLE;
            state_reg.ready <= 1'b1;
            state_reg.flow <= '0;
            state_reg.link <= '0;
            state_reg.flush <= 1'b0;
            state_reg.ne_set <= 1'b0;
            state_reg.exch <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flops
    assign o_ready = state_reg.ready;
    assign o_flow = state_reg.flow;
    assign o_link = state_reg.link;
    assign o_flush = state_reg.flush;
    assign o_ne_flag_set = state_reg.ne_set;
    assign o_exch = state_reg.exch;

    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    logic acc_exit;
    logic acc_br;
    assign acc_exit = accept && opc == OPC_EXIT;
    assign acc_br = accept && opc[6:3] == OPC_BR_GROUP && !i_top;

    exit_flush_a: assert property (
        acc_exit |=> o_flush && !o_ready ##1 !o_flush)
        else $error("exit did not void buffers");
    ne_flag_a: assert property (
        acc_exit |=> o_ne_flag_set == !$past(i_monitor_mode))
        else $error("normal-exit flag wrong for mode");
    drain_wait_a: assert property (
        $rose(o_exch.req) |-> $past(!i_pending) && $past(state_reg.st) == ST_DRAIN)
        else $error("exchange before results landed");
    exch_addr_a: assert property (
        $rose(o_exch.req) |-> o_exch.xadr == $past(i_xadr))
        else $error("exchange address not taken");
    save_p_a: assert property (
        acc_exit |=> o_exch.save_p == $past(i_issue.p_addr) + STEP_ONE)
        else $error("saved address not exit plus one");
    jump_b_a: assert property (
        accept && opc == OPC_JUMP_B && i_issue.parcel0[I_TOP:I_LO] == 3'h0
        |=> o_flow.valid && o_flow.taken && o_flow.target == $past(i_issue.bjk))
        else $error("register jump target wrong");
    imm_jump_a: assert property (
        accept && opc == OPC_JUMP |=> o_flow.valid && o_flow.taken
        && o_flow.target == {$past(i_issue.parcel0[TGT_HI:0]), $past(i_issue.parcel1)})
        else $error("immediate jump target wrong");
    ret_link_a: assert property (
        accept && opc == OPC_RET_JUMP
        |=> o_link.we && o_link.data == $past(i_issue.p_addr) + STEP_TWO && o_flow.taken)
        else $error("return link wrong");
    a_zero_pos_a: assert property (
        acc_br && opc[2:0] == BR_A_POS && i_issue.a0 == ADDR_ZERO |=> o_flow.taken)
        else $error("zero address test not positive");
    s_neg_a: assert property (
        acc_br && opc[2:0] == BR_S_NEG && i_issue.s0 == '0 |=> !o_flow.taken)
        else $error("zero scalar test taken as negative");
    fall_thru_a: assert property (
        acc_br ##1 !o_flow.taken
        |-> o_flow.valid && o_flow.target == $past(i_issue.p_addr) + STEP_TWO)
        else $error("failed branch did not fall through");
    br_taken_a: assert property (
        acc_br && opc[2:0] == BR_A_NONZERO && i_issue.a0 != ADDR_ZERO
        |=> o_flow.taken && o_flow.target == {$past(i_issue.parcel0[TGT_HI:0]),
        $past(i_issue.parcel1)})
        else $error("address nonzero branch not taken");

    // each address test against its own sense; sign bit alone decides
    a_zero_a: assert property (
        acc_br && opc[2:0] == BR_A_ZERO |=> o_flow.taken == ($past(i_issue.a0) == ADDR_ZERO))
        else $error("address zero test wrong");
    a_nonzero_a: assert property (
        acc_br && opc[2:0] == BR_A_NONZERO
        |=> o_flow.taken == ($past(i_issue.a0) != ADDR_ZERO))
        else $error("address nonzero test wrong");
    a_pos_a: assert property (
        acc_br && opc[2:0] == BR_A_POS |=> o_flow.taken == !$past(i_issue.a0[ADDR_W-1]))
        else $error("address positive test wrong");
    a_neg_a: assert property (
        acc_br && opc[2:0] == BR_A_NEG |=> o_flow.taken == $past(i_issue.a0[ADDR_W-1]))
        else $error("address negative test wrong");

    // same four tests on the scalar register
    s_zero_a: assert property (
        acc_br && opc[2:0] == BR_S_ZERO |=> o_flow.taken == ($past(i_issue.s0) == '0))
        else $error("scalar zero test wrong");
    s_nonzero_a: assert property (
        acc_br && opc[2:0] == BR_S_NONZERO |=> o_flow.taken == ($past(i_issue.s0) != '0))
        else $error("scalar nonzero test wrong");
    s_pos_a: assert property (
        acc_br && opc[2:0] == BR_S_POS |=> o_flow.taken == !$past(i_issue.s0[SREG_W-1]))
        else $error("scalar positive test wrong");
    s_neg_sign_a: assert property (
        acc_br && opc[2:0] == BR_S_NEG |=> o_flow.taken == $past(i_issue.s0[SREG_W-1]))
        else $error("scalar negative test wrong");

    // a taken branch lands on jkm, second parcel low
    br_target_a: assert property (
        acc_br ##1 o_flow.taken
        |-> o_flow.target == {$past(i_issue.parcel0[TGT_HI:0]), $past(i_issue.parcel1)})
        else $error("branch target not jkm");
    br_valid_a: assert property (
        acc_br |=> o_flow.valid && !o_link.we)
        else $error("branch gave no flow update");
    ret_target_a: assert property (
        accept && opc == OPC_RET_JUMP |=> o_flow.valid
        && o_flow.target == {$past(i_issue.parcel0[TGT_HI:0]), $past(i_issue.parcel1)})
        else $error("return jump target wrong");

    // exit decode must not look at ijk
    exit_ijk_a: assert property (
        accept && i_issue.parcel0[OPC_HI:OPC_LO] == OPC_EXIT
        |=> o_flush && !o_flow.valid && !o_link.we)
        else $error("exit decode depends on ijk");
    ne_mon_a: assert property (
        acc_exit && i_monitor_mode |=> !o_ne_flag_set)
        else $error("flag set in monitor mode");
    flush_once_a: assert property (
        o_flush |=> !o_flush)
        else $error("buffer void longer than a pulse");

    // nothing issues while the exit is in progress
    busy_hold_a: assert property (
        !o_ready |=> !o_flow.valid && !o_link.we)
        else $error("flow update while busy");
    pend_block_a: assert property (
        state_reg.st == ST_DRAIN && i_pending |=> !o_exch.req)
        else $error("exchange raised with results pending");
    req_busy_a: assert property (
        o_exch.req |-> !o_ready)
        else $error("ready while exchange requested");

    // request stands, unchanged, until taken
    req_hold_a: assert property (
        o_exch.req && !i_exch_ack |=> o_exch.req)
        else $error("exchange request dropped early");
    req_drop_a: assert property (
        o_exch.req && i_exch_ack |=> !o_exch.req && o_ready)
        else $error("exchange request not released");
    xadr_hold_a: assert property (
        o_exch.req && $past(o_exch.req) |-> $stable(o_exch.xadr))
        else $error("exchange address moved while requested");

    exit_user_c: cover property (acc_exit && !i_monitor_mode ##[1:20] $fell(o_exch.req));
    exit_mon_c: cover property (acc_exit && i_monitor_mode);
    ret_jump_c: cover property (accept && opc == OPC_RET_JUMP);
    br_miss_c: cover property (acc_br ##1 !o_flow.taken);
    br_take_c: cover property (acc_br ##1 o_flow.taken);
endmodule
`default_nettype wire

// ===== tb/bxs_exch_model.sv
`timescale 1ns/10ps
`default_nettype none
module bxs_exch_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_req,
    input wire logic [3:0] i_delay,
    output logic o_ack
);
    logic [3:0] cnt_reg;
    // exchange side answers after a set wait; delay 0 acts at once
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg <= 4'h0;
            o_ack <= 1'b0;
        end else if (i_req && !o_ack) begin
            if (cnt_reg == i_delay) begin
                o_ack <= 1'b1;
                cnt_reg <= 4'h0;
            end else begin
                cnt_reg <= cnt_reg + 4'h1;
            end
        end else begin
            o_ack <= 1'b0; // one pulse only, so a sticky req would show
        end
    end
endmodule
`default_nettype wire

// ===== tb/bxs_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module bxs_top_bench;
    import bxs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic mon = 1'b0;
    logic pend = 1'b0;
    logic ack;
    logic rdy, fl, ne;
    logic [7:0] xadr = 8'h00;
    logic [3:0] dly = 4'h0;
    bxs_issue_type iss = '0;
    bxs_flow_type fw;
    bxs_link_type lk;
    bxs_exch_type ex;
    int err_count = 0;
    int n_tests = 0;

    always #20 clk = ~clk;

    bxs_top bxs_top_i(.i_core_clk(clk), .i_rst_n(rst_n), .i_issue(iss), .i_monitor_mode(mon),
        .i_pending(pend), .i_xadr(xadr), .i_exch_ack(ack), .o_ready(rdy), .o_flow(fw),
        .o_link(lk), .o_flush(fl), .o_ne_flag_set(ne), .o_exch(ex));
    bxs_exch_model bxs_exch_model_i(.i_clk(clk), .i_rst_n(rst_n), .i_req(ex.req),
        .i_delay(dly), .o_ack(ack));

    task chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // called at a falling edge; keeps valid up so calls run back to back
    task send(input logic [6:0] op, input logic [23:0] t, input logic [23:0] p);
        iss.valid = 1'b1;
        iss.parcel0 = {op, 1'b0, t[23:16]};
        iss.parcel1 = t[15:0];
        iss.p_addr = p;
        @(negedge clk);
    endtask

    task t_jumps;
        iss.bjk = 24'h00ABCD;
        send(OPC_JUMP, 24'hFEDCBA, 24'h000100);
        chk({fw.valid, fw.taken, fw.target}, {2'b11, 24'hFEDCBA});
        chk(lk.we, 1'b0);
        send(OPC_JUMP_B, 24'h030000, 24'h000200);
        chk({fw.valid, fw.taken, fw.target}, {2'b11, 24'h00ABCD});
        send(OPC_RET_JUMP, 24'h123456, 24'hFFFFFF);
        chk({lk.we, lk.data}, {1'b1, 24'h000001});
        chk(fw.target, 24'h123456);
        iss.valid = 1'b0;
        @(negedge clk);
        chk({lk.we, fw.valid}, 2'b00);
    endtask

    // every test against zero, positive and negative registers
    task t_branch;
        logic [23:0] av[3];
        logic [63:0] sv[3];
        logic z, n, tk;
        av[0] = 24'h000000; av[1] = 24'h000005; av[2] = 24'h800000;
        sv[0] = 64'h0; sv[1] = 64'h7; sv[2] = 64'h8000000000000000;
        for (int k = 0; k < 3; k++) begin
            iss.a0 = av[k];
            iss.s0 = sv[(k + 1) % 3];
            for (int b = 0; b < 8; b++) begin
                z = (b < 4) ? (av[k] == 24'h0) : (sv[(k + 1) % 3] == 64'h0);
                n = (b < 4) ? av[k][23] : sv[(k + 1) % 3][63];
                case (b % 4)
                    0: tk = z;
                    1: tk = !z;
                    2: tk = !n;
                    default: tk = n;
                endcase
                send({4'h1, 3'(b)}, 24'h00A000 + 24'(b), 24'h000400);
                chk({fw.valid, fw.taken, fw.target},
                    {1'b1, tk, tk ? 24'h00A000 + 24'(b) : 24'h000402});
            end
        end
        iss.valid = 1'b0;
        @(negedge clk);
    endtask

    task t_exit(input logic m, input logic [3:0] d);
        int i;
        mon = m;
        dly = d;
        xadr = 8'h11;
        pend = 1'b1;
        send(OPC_EXIT, 24'hFF0000, 24'h000777); // nonzero ijk must not matter
        chk({fl, ne, rdy, ex.req}, {1'b1, !m, 2'b00});
        chk(ex.save_p, 24'h000778);
        iss.parcel0 = {OPC_JUMP, 9'h000}; // held while busy, must be dropped
        xadr = 8'h5A;
        repeat (3) begin
            @(negedge clk);
            chk({ex.req, fw.valid, fl}, 3'b000);
        end
        iss.valid = 1'b0;
        pend = 1'b0;
        @(negedge clk);
        chk({ex.req, ex.xadr}, {1'b1, 8'h5A});
        i = 0;
        while (ex.req === 1'b1 && i < 40) begin
            @(negedge clk);
            i++;
        end
        chk(i >= int'(d), 1'b1);
        chk({rdy, ex.req}, 2'b10);
    endtask

    task close_out;
        $display("tests %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // whole run is under a hundred cycles; the 5000-cycle limit leaves wide margin
    initial begin
        #200000;
        err_count++;
        close_out;
    end

    initial begin
        repeat (16) @(negedge clk);
        chk({rdy, fl, ne, ex.req}, 4'b1000);
        rst_n = 1'b1;
        @(negedge clk);
        t_jumps;
        t_branch;
        t_exit(1'b0, 4'h0);
        t_exit(1'b1, 4'h5);
        t_jumps;
        close_out;
    end
endmodule
`default_nettype wire
